// >>> logic/prs_defines.vh
// register map, field layout, reset values and timing constants
`ifndef PRS_DEFINES_VH
`define PRS_DEFINES_VH
`define PRS_CLK_HZ          40000000
`define PRS_STEP_FINE_NS    1024000
`define PRS_STEP_COARSE_NS  32768000
`define PRS_STEP_FINE_CYC   ((`PRS_CLK_HZ / 1000) * 1024 / 1000)
`define PRS_STEP_COARSE_CYC ((`PRS_CLK_HZ / 1000) * 32768 / 1000)
`define PRS_OFS_RESET_CFG   8'h99
`define PRS_OFS_CONV_CTRL   8'h80
`define PRS_OFS_SLOT_MAP    8'h84
`define PRS_OFS_CORE_A      8'ha0
`define PRS_OFS_MEM_CONF    8'ha1
`define PRS_OFS_CORE_B      8'hb6
`define PRS_OFS_MEM_B       8'hb7
`define PRS_OFS_STATUS      8'hc0
`define PRS_OFS_SLOT_DELAY  8'h88
`define PRS_OFS_MEM_A       8'ha4
`define PRS_RESET_CFG_RST   8'h45
`define PRS_CONV_CTRL_RST   8'h06
`define PRS_VOLT_B_RST      8'h80
`define PRS_VOLT_A_RST      8'h00
`define PRS_CONF_RST        8'h00
`define PRS_SLOTDLY_RST     8'h04
`define PRS_TRIG_WAKE       2'h0
`define PRS_TRIG_SYS        2'h1
`define PRS_TRIG_PWR        2'h2
`define PRS_TRIG_PMIC       2'h3
`define PRS_MODE_BYREG      2'h0
`define PRS_BIT_CONV_EN     0
`define PRS_BIT_AUTO_ON     1
`define PRS_BIT_FREQ_SEL    2
`define PRS_BIT_RES_MODE    3
`define PRS_SYS_LAST        3'h4
`define PRS_PWR_LAST        3'h6
`define PRS_SEC_LAST        3'h7
`define PRS_SLOT_MAP_RST    8'h02
`define PRS_DELAY_SLOT      3'h3
`define PRS_BIT_SLEEP       7
`define PRS_BIT_COARSE      5
`define PRS_FINE_LAST       6'h1f
`endif

// >>> logic/prs_rail_sequencer.v
// rail sequencer: converter gate, slot sequencer, reset timer, standby select
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "prs_defines.vh"
// Summary of operation
// - converter rail on only when rail enable and auto power-on are both 1
// - rail stays on while input above undervoltage threshold, off below it
// - frequency select bit 1 chooses automatic frequency mode
// - with auto power-on set, sequencing starts once converter rail is valid
// - system request runs slots up to the last system slot
// - each output or delay step owns its own numbered slot
// - switch gate output goes active when its slot is reached
// - reset output released after system domain completes plus reset delay
// - bits 7:6 choose reset timer trigger: wake, system, power, pmic exit
// - delay bits 5:0: 1.024 ms steps to 011111, 32.768 ms steps above
// - power request continues the sequence to the last power slot
// - secondary request enables regulators mapped to its slots
// - standby input high picks A settings, low picks B settings
// - standby voltage taken from B register when B settings selected
// - pulse frequency mode under B when sleep bit 1 and mode field 00
// - mode 00 lets selected A or B sleep bit choose sleep or synchronous
module prs_rail_sequencer #(
   parameter FINE_CYC   = `PRS_STEP_FINE_CYC,
   parameter COARSE_CYC = `PRS_STEP_COARSE_CYC,
   parameter SLOT_CYC   = 16'h0100
) (
   input  wire        clk,
   input  wire        reset,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   input  wire        input_above_uvlo,
   input  wire        system_domain_request,
   input  wire        power_domain_request,
   input  wire        secondary_domain_request,
   input  wire        external_wake_trigger,
   input  wire        standby_sleep_n,
   output reg         conv_rail_on,
   output reg         conv_auto_freq,
   output reg  [7:0]  slot_enable_out,
   output reg         switch_gate_output,
   output reg         reset_release_out_n,
   output reg  [7:0]  core_reg_voltage,
   output reg  [7:0]  mem_reg_voltage,
   output reg         core_reg_pfm,
   output reg         mem_reg_pfm
);
   localparam ST_OFF  = 3'h0;
   localparam ST_IDLE = 3'h1;
   localparam ST_STEP = 3'h2;
   localparam ST_WAIT = 3'h3;
   localparam ST_HOLD = 3'h4;

   reg [7:0]  reset_cfg_reg;
   reg [7:0]  conv_ctrl_reg;
   reg [7:0]  slot_map_reg;
   reg [7:0]  slot_delay_reg;
   reg [7:0]  core_a_reg;
   reg [7:0]  core_b_reg;
   reg [7:0]  mem_a_reg;
   reg [7:0]  mem_b_reg;
   reg [7:0]  core_conf_reg;
   reg [7:0]  mem_conf_reg;
   reg [2:0]  state_reg;
   reg [2:0]  slot_reg;
   reg [15:0] slot_cnt_reg;
   reg        system_domain_up_reg;
   reg        power_domain_up_reg;
   reg        timer_run_reg;
   reg [5:0]  tick_cnt_reg;
   reg [31:0] sub_cnt_reg;
   reg        ack_reg;
   reg        trig_seen_reg;

   wire       req      = avs_read | avs_write;
   wire       wr_go    = avs_write & ack_reg;
   wire [2:0] target;
   wire       rail_ok;
   reg        trig_hit;
   wire [31:0] status_word;
   wire        system_domain_up_next;
   wire        power_domain_up_next;

   // one wait state per access, answer on the second edge
   assign avs_waitrequest = req & ~ack_reg;

   // decodes a regulator mode: mode 00 follows the selected sleep bit
   function reg_pfm;
      input [1:0] mode;
      input       sleep_a;
      input       sleep_b;
      input       use_b;
      begin
         reg_pfm = (mode == `PRS_MODE_BYREG) &
                   (use_b ? sleep_b : sleep_a);
      end
   endfunction

   // a domain is up once its last slot has settled, and it stays up
   // while the sequencer waits on that slot on the way back down
   function dom_up;
      input [2:0] slot;
      input [2:0] last;
      input       idle;
      input       was_up;
      begin
         dom_up = (slot > last) || (slot == last && (idle || was_up));
      end
   endfunction

   // last sub-count of one reset delay step, fine or coarse
   function [31:0] step_last;
      input coarse;
      begin
         if (coarse)
            step_last = COARSE_CYC - 1;
         else
            step_last = FINE_CYC - 1;
      end
   endfunction

   // no domain is up from the cycle after the sequencer enters the off state
   assign system_domain_up_next = (state_reg != ST_OFF) &&
                        dom_up(slot_reg, `PRS_SYS_LAST,
                               state_reg == ST_IDLE, system_domain_up_reg);
   assign power_domain_up_next = (state_reg != ST_OFF) &&
                        dom_up(slot_reg, `PRS_PWR_LAST,
                               state_reg == ST_IDLE, power_domain_up_reg);

   assign status_word = {16'h0, reset_release_out_n, power_domain_up_reg,
                         system_domain_up_reg, rail_ok, 1'b0, state_reg, 5'h0,
                         slot_reg};

   assign rail_ok = conv_ctrl_reg[`PRS_BIT_CONV_EN] &
                    conv_ctrl_reg[`PRS_BIT_AUTO_ON] & input_above_uvlo;
   assign target = !system_domain_request    ? 3'h0 :
                   !power_domain_request     ? `PRS_SYS_LAST :
                   !secondary_domain_request ? `PRS_PWR_LAST :
                                               `PRS_SEC_LAST;

   always @* begin
      case (reset_cfg_reg[7:6])
         `PRS_TRIG_WAKE: trig_hit = external_wake_trigger;
         `PRS_TRIG_SYS:  trig_hit = system_domain_up_reg;
         `PRS_TRIG_PWR:  trig_hit = power_domain_up_reg;
         `PRS_TRIG_PMIC: trig_hit = (state_reg != ST_OFF);
         default:        trig_hit = 1'b0;
      endcase
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ack_reg        <= 1'b0;
         avs_readdata   <= 32'h0;
         reset_cfg_reg  <= `PRS_RESET_CFG_RST;
         conv_ctrl_reg  <= `PRS_CONV_CTRL_RST;
         slot_map_reg   <= `PRS_SLOT_MAP_RST;
         slot_delay_reg <= `PRS_SLOTDLY_RST;
         core_a_reg     <= `PRS_VOLT_A_RST;
         mem_a_reg      <= `PRS_VOLT_A_RST;
         core_b_reg     <= `PRS_VOLT_B_RST;
         mem_b_reg      <= `PRS_VOLT_B_RST;
         core_conf_reg  <= `PRS_CONF_RST;
         mem_conf_reg   <= `PRS_CONF_RST;
      end else begin
         ack_reg <= req & ~ack_reg;
         if (req & ~ack_reg) begin
            case (avs_address)
               `PRS_OFS_RESET_CFG:  avs_readdata <= {24'h0, reset_cfg_reg};
               `PRS_OFS_CONV_CTRL:  avs_readdata <= {24'h0, conv_ctrl_reg};
               `PRS_OFS_SLOT_MAP:   avs_readdata <= {24'h0, slot_map_reg};
               `PRS_OFS_SLOT_DELAY: avs_readdata <= {24'h0, slot_delay_reg};
               `PRS_OFS_CORE_A:     avs_readdata <= {24'h0, core_a_reg};
               `PRS_OFS_MEM_A:      avs_readdata <= {24'h0, mem_a_reg};
               `PRS_OFS_CORE_B:     avs_readdata <= {24'h0, core_b_reg};
               `PRS_OFS_MEM_B:      avs_readdata <= {24'h0, mem_b_reg};
               `PRS_OFS_MEM_CONF:   avs_readdata <= {24'h0, mem_conf_reg};
               `PRS_OFS_STATUS:     avs_readdata <= status_word;
               default:             avs_readdata <= 32'h0;
            endcase
         end
         if (wr_go) begin
            case (avs_address)
               `PRS_OFS_RESET_CFG:  reset_cfg_reg  <= avs_writedata[7:0];
               `PRS_OFS_CONV_CTRL:  conv_ctrl_reg  <= avs_writedata[7:0];
               `PRS_OFS_SLOT_MAP:   slot_map_reg   <= avs_writedata[7:0];
               `PRS_OFS_SLOT_DELAY: slot_delay_reg <= avs_writedata[7:0];
               `PRS_OFS_CORE_A:     core_a_reg     <= avs_writedata[7:0];
               `PRS_OFS_MEM_A:      mem_a_reg      <= avs_writedata[7:0];
               `PRS_OFS_CORE_B:     core_b_reg     <= avs_writedata[7:0];
               `PRS_OFS_MEM_B:      mem_b_reg      <= avs_writedata[7:0];
               `PRS_OFS_MEM_CONF:   mem_conf_reg   <= avs_writedata[7:0];
               default:             core_conf_reg  <= core_conf_reg;
            endcase
         end
      end
   end

   // slot sequencer: up when target above current slot, down in reverse
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg       <= ST_OFF;
         slot_reg        <= 3'h0;
         slot_cnt_reg    <= 16'h0;
         slot_enable_out <= 8'h0;
         system_domain_up_reg      <= 1'b0;
         power_domain_up_reg      <= 1'b0;
      end else begin
         // held through later steps so reset is not pulsed while the
         // power domain comes up
         system_domain_up_reg <= system_domain_up_next;
         power_domain_up_reg <= power_domain_up_next;
         case (state_reg)
            ST_OFF: begin
               slot_reg        <= 3'h0;
               slot_enable_out <= 8'h0;
               if (rail_ok)
                  state_reg <= ST_IDLE;
            end
            ST_IDLE: begin
               if (!rail_ok)
                  state_reg <= ST_OFF;
               else if (target != slot_reg)
                  state_reg <= ST_STEP;
            end
            ST_STEP: begin
               // one slot per step, ascending up, descending down
               if (target > slot_reg) begin
                  slot_reg <= slot_reg + 3'h1;
                  slot_enable_out[slot_reg + 3'h1] <= 1'b1;
               end else if (target < slot_reg) begin
                  slot_enable_out[slot_reg] <= 1'b0;
                  slot_reg <= slot_reg - 3'h1;
               end
               slot_cnt_reg <= 16'h0;
               state_reg    <= ST_WAIT;
            end
            ST_WAIT: begin
               // delay slot stretches its step by slot_delay_reg factor
               slot_cnt_reg <= slot_cnt_reg + 16'h1;
               if (!rail_ok)
                  state_reg <= ST_OFF;
               else if (slot_cnt_reg >= SLOT_CYC - 16'h1)
                  state_reg <= (slot_reg == `PRS_DELAY_SLOT &&
                                slot_delay_reg != 8'h0 &&
                                target > slot_reg) ? ST_HOLD : ST_IDLE;
            end
            ST_HOLD: begin
               // a lost rail ends the delay slot at once
               slot_cnt_reg <= slot_cnt_reg + 16'h1;
               if (!rail_ok)
                  state_reg <= ST_OFF;
               else if (slot_cnt_reg[15:8] >= slot_delay_reg)
                  state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_OFF;
         endcase
      end
   end

   // reset delay timer
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         timer_run_reg       <= 1'b0;
         trig_seen_reg       <= 1'b0;
         tick_cnt_reg        <= 6'h0;
         sub_cnt_reg         <= 32'h0;
         reset_release_out_n <= 1'b0;
      end else if (!system_domain_up_reg) begin
         timer_run_reg       <= 1'b0;
         trig_seen_reg       <= 1'b0;
         tick_cnt_reg        <= 6'h0;
         sub_cnt_reg         <= 32'h0;
         reset_release_out_n <= 1'b0;
      end else if (!trig_seen_reg) begin
         if (trig_hit) begin
            trig_seen_reg <= 1'b1;
            timer_run_reg <= 1'b1;
            // coarse codes start past the fine range: code 32 is one
            // coarse step, equal to 32 fine steps
            tick_cnt_reg  <= reset_cfg_reg[`PRS_BIT_COARSE] ?
                             `PRS_FINE_LAST : 6'h0;
         end
      end else if (timer_run_reg) begin
         if (tick_cnt_reg >= reset_cfg_reg[5:0]) begin
            timer_run_reg       <= 1'b0;
            reset_release_out_n <= 1'b1;
         end else if (sub_cnt_reg >=
                      step_last(reset_cfg_reg[`PRS_BIT_COARSE])) begin
            sub_cnt_reg  <= 32'h0;
            tick_cnt_reg <= tick_cnt_reg + 6'h1;
         end else
            sub_cnt_reg <= sub_cnt_reg + 32'h1;
      end
   end

   // converter and regulator outputs
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         conv_rail_on       <= 1'b0;
         conv_auto_freq     <= 1'b0;
         switch_gate_output <= 1'b0;
         core_reg_voltage   <= 8'h0;
         mem_reg_voltage    <= 8'h0;
         core_reg_pfm       <= 1'b0;
         mem_reg_pfm        <= 1'b0;
      end else begin
         conv_rail_on       <= rail_ok;
         conv_auto_freq     <= conv_ctrl_reg[`PRS_BIT_FREQ_SEL];
         switch_gate_output <= slot_enable_out[slot_map_reg[2:0]];
         core_reg_voltage <= standby_sleep_n ? core_a_reg : core_b_reg;
         mem_reg_voltage  <= standby_sleep_n ? mem_a_reg : mem_b_reg;
         core_reg_pfm <= reg_pfm(core_conf_reg[7:6],
                                 core_a_reg[`PRS_BIT_SLEEP],
                                 core_b_reg[`PRS_BIT_SLEEP],
                                 ~standby_sleep_n);
         mem_reg_pfm  <= reg_pfm(mem_conf_reg[7:6],
                                 mem_a_reg[`PRS_BIT_SLEEP],
                                 mem_b_reg[`PRS_BIT_SLEEP],
                                 ~standby_sleep_n);
      end
   end
endmodule // prs_rail_sequencer
`default_nettype wire

// >>> dv/prs_rail_sequencer_properties.sv
// assertion checker bound to the rail sequencer
`timescale 1ns/1ps
`default_nettype none
module prs_rail_sequencer_properties (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic        avs_waitrequest,
   input wire logic        input_above_uvlo,
   input wire logic        system_domain_request,
   input wire logic        power_domain_request,
   input wire logic        secondary_domain_request,
   input wire logic        conv_rail_on,
   input wire logic        conv_auto_freq,
   input wire logic [7:0]  slot_enable_out,
   input wire logic        switch_gate_output,
   input wire logic        reset_release_out_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire logic wr_ctl;
   assign wr_ctl = avs_write && !avs_waitrequest && avs_address == 8'h80;
   a_rail_uvlo: assert property (
      conv_rail_on |-> $past(input_above_uvlo))
      else $error("rail on below threshold");
   a_rail_drop: assert property (
      $fell(input_above_uvlo) |=> !conv_rail_on)
      else $error("rail kept on after undervoltage");
   a_rail_gate: assert property (
      wr_ctl && input_above_uvlo |->
      ##3 conv_rail_on == $past(&avs_writedata[1:0], 3))
      else $error("rail enable not both control bits");
   a_freq_mode: assert property (
      wr_ctl |-> ##2 conv_auto_freq == $past(avs_writedata[2], 2))
      else $error("frequency mode not taken from control");
   a_slot_order: assert property (
      (slot_enable_out[7:2] & ~slot_enable_out[6:1]) == 6'h00)
      else $error("slot active before lower slot");
   a_slot_step: assert property (
      conv_rail_on |->
      $countones(slot_enable_out ^ $past(slot_enable_out)) <= 1)
      else $error("more than one slot changed at once");
   a_sys_start: assert property (
      $rose(slot_enable_out[1]) |->
      $past(system_domain_request && conv_rail_on))
      else $error("sequence started without request or rail");
   a_pwr_slot: assert property (
      $rose(slot_enable_out[5]) |-> $past(power_domain_request))
      else $error("power slot without request");
   a_sec_slot: assert property (
      $rose(slot_enable_out[7]) |-> $past(secondary_domain_request))
      else $error("secondary slot without request");
   a_rel_sys: assert property (
      $rose(reset_release_out_n) |-> slot_enable_out[4])
      else $error("reset released before system domain");
   a_gate_slot: assert property (
      switch_gate_output |-> $past(slot_enable_out) != 8'h00)
      else $error("switch gate active with no slot");
   c_release: cover property ($rose(reset_release_out_n));
   c_sec_up: cover property ($rose(slot_enable_out[7]));
   c_walk_down: cover property ($fell(slot_enable_out[4]));
endmodule // prs_rail_sequencer_properties
bind prs_rail_sequencer prs_rail_sequencer_properties i_prs_props (
   .clk, .reset, .avs_address, .avs_write, .avs_writedata,
   .avs_waitrequest, .input_above_uvlo, .system_domain_request,
   .power_domain_request, .secondary_domain_request, .conv_rail_on,
   .conv_auto_freq, .slot_enable_out, .switch_gate_output,
   .reset_release_out_n);
`default_nettype wire

// >>> dv/prs_pch_model.sv
// hub and controller model: sleep signals rise and fall in order
`timescale 1ns/1ps
`default_nettype none
module prs_pch_model #(parameter GAP = 8) (
   input  wire logic       clk,
   input  wire logic [1:0] level,
   output wire logic       suspend_sleep_n,
   output wire logic       s4_sleep_n,
   output wire logic       s3_sleep_n
);
   logic [1:0] cur = 2'h0;
   int         cnt = 0;
   // one state step per gap, never skipping a level
   always @(posedge clk) begin
      cnt <= (cnt == GAP) ? 0 : cnt + 1;
      if (cnt == GAP && cur < level) cur <= cur + 2'h1;
      if (cnt == GAP && cur > level) cur <= cur - 2'h1;
   end
   assign suspend_sleep_n = cur != 2'h0;
   assign s4_sleep_n      = cur[1];
   assign s3_sleep_n      = cur == 2'h3;
endmodule // prs_pch_model
`default_nettype wire

// >>> dv/prs_rail_sequencer_tb.sv
// self-checking bench for the rail sequencer
`timescale 1ns/1ps
`default_nettype none
module prs_rail_sequencer_tb;
   logic        clk = 0, reset = 1, avs_read = 0, avs_write = 0;
   logic [7:0]  avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic        avs_waitrequest, uvlo = 1, wake = 0, stby_n = 1;
   logic [1:0]  lvl = 2'h0;
   logic        sys_req, pwr_req, sec_req, rail_on, freq, gate, rel_n;
   logic        core_pfm, mem_pfm;
   logic [7:0]  slots, core_v, mem_v, q, obs;
   int          err_total = 0, total_checks = 0, t, base;
   int          codes[4] = '{1, 31, 32, 63};
   assign obs = {slots[7:1], rel_n};
   prs_pch_model i_prs_pch_model (.clk, .level(lvl),
      .suspend_sleep_n(sys_req), .s4_sleep_n(pwr_req), .s3_sleep_n(sec_req));
   prs_rail_sequencer #(.FINE_CYC(4), .COARSE_CYC(16), .SLOT_CYC(4))
      i_prs_rail_sequencer (.clk, .reset, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .input_above_uvlo(uvlo), .system_domain_request(sys_req),
      .power_domain_request(pwr_req), .secondary_domain_request(sec_req),
      .external_wake_trigger(wake), .standby_sleep_n(stby_n),
      .conv_rail_on(rail_on), .conv_auto_freq(freq),
      .slot_enable_out(slots), .switch_gate_output(gate),
      .reset_release_out_n(rel_n), .core_reg_voltage(core_v),
      .mem_reg_voltage(mem_v), .core_reg_pfm(core_pfm), .mem_reg_pfm(mem_pfm));
   initial forever #12.5 clk = ~clk;
   task test_done;
      if (err_total == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task acc(input logic rd, input logic [7:0] a, d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= {24'h0, d};
      do @(posedge clk); while (avs_waitrequest !== 1'b0 && n++ < 50);
      chk(avs_waitrequest, 0);
      q = avs_readdata[7:0];
      avs_read <= 0;
      avs_write <= 0;
   endtask
   // wait for one observed bit, counting cycles
   task wt(input int i, input logic v, output int c);
      c = 0;
      while (obs[i] !== v && c < 3000) begin
         @(posedge clk);
         c++;
      end
   endtask
   // restart from all slots off, then bring up the system domain
   task arm(input logic [7:0] cfg, output int c);
      lvl <= 2'h0;
      wt(1, 0, c);
      acc(0, 8'h99, cfg);
      lvl <= 2'h1;
      wt(4, 1, c);
   endtask
   function int dly(int k);
      return k < 32 ? k * 4 : (k - 31) * 16;
   endfunction
   initial begin
      repeat (16) @(posedge clk);
      reset <= 0;
      acc(1, 8'h99, 0);
      chk(q, 8'h45);
      acc(1, 8'h80, 0);
      chk(q, 8'h06);
      acc(1, 8'h90, 0);
      chk(q, 8'h00);
      chk(rail_on, 0);
      acc(0, 8'h88, 0);
      acc(0, 8'h80, 8'h07);
      acc(1, 8'h80, 0);
      chk(freq, 1);
      chk(rail_on, 1);
      arm(8'h40, t);
      wt(0, 1, base);
      foreach (codes[k]) begin
         arm({2'b01, codes[k][5:0]}, t);
         wt(0, 1, t);
         chk(t - base, dly(codes[k]));
      end
      for (int k = 0; k < 2; k++) begin
         arm({k[0], 7'h00}, t);
         repeat (40) @(posedge clk);
         chk(rel_n, 0);
         lvl <= 2'h3;
         wake <= k == 0;
         wt(7, 1, t);
         chk(gate, 1);
         wt(0, 1, t);
         chk(t < 3000, 1);
         wake <= 0;
      end
      arm(8'hc0, t);
      wt(0, 1, t);
      chk(t, base);
      acc(0, 8'ha0, 8'h33);
      acc(0, 8'hb6, 8'h9a);
      acc(0, 8'hb7, 8'h15);
      chk(core_v, 8'h33);
      chk(core_pfm, 0);
      stby_n <= 0;
      repeat (3) @(posedge clk);
      chk(core_v, 8'h9a);
      chk(mem_v, 8'h15);
      chk(core_pfm, 1);
      chk(mem_pfm, 0);
      uvlo <= 0;
      repeat (3) @(posedge clk);
      chk(rail_on, 0);
      test_done;
   end
   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      test_done;
   end
endmodule // prs_rail_sequencer_tb
`default_nettype wire
